// >>> hw/rts_pkg.sv
// Constants and types shared by the reload-synced trigger scheduler
package rts_pkg;
   localparam int unsigned GEN_N = 2;
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned MEM_AW = 24;
   localparam int unsigned ENTRY_W = 16;
   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFS_CTRL = 12'h000;
   localparam logic [ADDR_W-1:0] OFS_IRQ_EN = 12'h004;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h008;
   localparam logic [ADDR_W-1:0] OFS_BASE_LOW = 12'h00c;
   localparam logic [ADDR_W-1:0] OFS_BASE_MID = 12'h010;
   localparam logic [ADDR_W-1:0] OFS_BASE_HIGH = 12'h014;
   localparam logic [ADDR_W-1:0] OFS_GEN0_PRI = 12'h018;
   localparam logic [ADDR_W-1:0] OFS_GEN0_ALT = 12'h01c;
   localparam logic [ADDR_W-1:0] OFS_GEN1_PRI = 12'h020;
   localparam logic [ADDR_W-1:0] OFS_GEN1_ALT = 12'h024;
   localparam logic [ADDR_W-1:0] OFS_COUNT = 12'h028;
   // Control register fields
   localparam int unsigned CTRL_UNIT_EN = 0;
   localparam int unsigned CTRL_GEN_EN = 1;
   localparam int unsigned CTRL_LOAD_OK = 3;
   // Status register fields
   localparam int unsigned STAT_DONE = 0;
   localparam int unsigned STAT_ACTIVE = 4;
   localparam int unsigned STAT_ALT = 8;
   // Pointer byte lane shifts
   localparam int unsigned BASE_MID_SH = 8;
   localparam int unsigned BASE_HIGH_SH = 16;
   // Reset values and the counter saturation limit
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [ENTRY_W-1:0] RST_ENTRY = 16'h0000;
   localparam logic [ENTRY_W-1:0] COUNT_MAX = 16'hffff;
   // A zero entry after the first ends the list
   localparam logic [ENTRY_W-1:0] END_MARK = 16'h0000;

   typedef enum logic [1:0] {
      GEN_IDLE,
      GEN_FETCH,
      GEN_ARMED,
      GEN_DONE
   } rts_gen_st_t;

   typedef enum logic [1:0] {
      FET_IDLE,
      FET_BUSY,
      FET_GAP
   } rts_fet_st_t;
endpackage : rts_pkg

// >>> hw/rts_fetch.sv
// List entry fetcher: shares one memory read port between generators
`timescale 1ns/1ps
module rts_fetch (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic [rts_pkg::GEN_N-1:0] req_i,
   input wire logic [rts_pkg::GEN_N-1:0][rts_pkg::MEM_AW-1:0] addr_i,
   output logic [rts_pkg::GEN_N-1:0] done_o,
   output logic [rts_pkg::ENTRY_W-1:0] data_o,
   output logic busy_o,
   output logic owner_o,
   output logic mem_req_o,
   output logic [rts_pkg::MEM_AW-1:0] mem_addr_o,
   input wire logic mem_ack_i,
   input wire logic [rts_pkg::ENTRY_W-1:0] mem_rdata_i
);
   import rts_pkg::*;

   typedef struct packed {
      rts_fet_st_t st;
      logic owner;
      logic [GEN_N-1:0] done;
      logic [ENTRY_W-1:0] data;
      logic req;
      logic [MEM_AW-1:0] addr;
   } rts_fet_t;

   rts_fet_t s_q, s_d;

   always_comb begin
      s_d = s_q;
      s_d.done = '0;
      unique case (s_q.st)
         FET_IDLE: begin
            // Fixed priority: generator 0 first
            if (req_i[0] || req_i[1]) begin
               s_d.owner = ~req_i[0];
               s_d.addr = req_i[0] ? addr_i[0] : addr_i[1];
               s_d.req = 1'b1;
               s_d.st = FET_BUSY;
            end
         end
         FET_BUSY: begin
            if (mem_ack_i) begin
               s_d.req = 1'b0;
               s_d.data = mem_rdata_i;
               s_d.done[s_q.owner] = 1'b1;
               s_d.st = FET_GAP;
            end
         end
         FET_GAP: begin
            // One idle cycle so the requester can drop its request
            s_d.st = FET_IDLE;
         end
         default: s_d.st = FET_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         s_q <= '{st: FET_IDLE, owner: 1'b0, done: '0, data: RST_ENTRY,
                  req: 1'b0, addr: '0};
      end else begin
         s_q <= s_d;
      end
   end

   assign done_o = s_q.done;
   assign data_o = s_q.data;
   assign busy_o = (s_q.st == FET_BUSY);
   assign owner_o = s_q.owner;
   assign mem_req_o = s_q.req;
   assign mem_addr_o = s_q.addr;
endmodule : rts_fetch

// >>> hw/rts_sched.sv
// Reload-synced trigger scheduler with two list-driven generators
//
// How it works
// [RULE1] Two generators, each with own enable
// [RULE2] Generator 0 feeds converter 0, 1 feeds 1
// [RULE3] Reload clears counter, loads first list entry
// [RULE4] Reload tells enabled converters: new cycle
// [RULE5] Counter match fires one trigger, then advance
// [RULE6] Counter increments once every bus clock; here it holds at COUNT_MAX
// [RULE7] Trigger times read from system memory
// [RULE8] Base pointer from low, mid, high bytes
// [RULE9] List indices count 16-bit entries from base
// [RULE10] Alternate between primary and alternate index
// [RULE11] List end with enable raises generator interrupt
// [RULE12] Load-ok output tells others buffers are ready
// [RULE13] Converter with flow code 3 follows signals
// [RULE14] Converter stores result despite restart
// [RULE15] Converter writes 12-bit left-justified results
// [RULE16] Converter 0 interrupts at its list end
// [RULE17] Enabled unit passes reload straight on
// [RULE18] Finished generator stays silent until reload
//
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/1ps
module rts_sched (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [rts_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic pwm_reload_i,
   output logic reload_o,
   output logic [rts_pkg::GEN_N-1:0] cycle_start_o,
   output logic [rts_pkg::GEN_N-1:0] trigger_o,
   output logic [rts_pkg::GEN_N-1:0] done_irq_o,
   output logic load_ok_o,
   output logic mem_req_o,
   output logic [rts_pkg::MEM_AW-1:0] mem_addr_o,
   input wire logic mem_ack_i,
   input wire logic [rts_pkg::ENTRY_W-1:0] mem_rdata_i
);
   import rts_pkg::*;

   typedef struct packed {
      logic unit_en;
      logic [GEN_N-1:0] gen_en;
      logic load_ok;
      logic [GEN_N-1:0] irq_en;
      logic [GEN_N-1:0] done;
      logic [7:0] base_low;
      logic [7:0] base_mid;
      logic [7:0] base_high;
      logic [GEN_N-1:0][7:0] pri_idx;
      logic [GEN_N-1:0][7:0] alt_idx;
      logic [ENTRY_W-1:0] count;
      rts_gen_st_t [GEN_N-1:0] st;
      logic [GEN_N-1:0][ENTRY_W-1:0] value;
      logic [GEN_N-1:0][7:0] entry;
      logic [GEN_N-1:0] alt_sel;
      logic [GEN_N-1:0] stale;
      logic [GEN_N-1:0] trig;
      logic [GEN_N-1:0] cstart;
      logic [GEN_N-1:0] irq;
      logic reload;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } rts_state_t;

   rts_state_t s_q, s_d;

   logic [GEN_N-1:0] fet_req;
   logic [GEN_N-1:0][MEM_AW-1:0] fet_addr;
   logic [GEN_N-1:0] fet_done;
   logic [ENTRY_W-1:0] fet_data;
   logic fet_busy;
   logic fet_owner;
   logic [MEM_AW-1:0] base_ptr;

   // Pointer bytes assembled into one 24-bit base
   assign base_ptr = {s_q.base_high, s_q.base_mid, s_q.base_low}; // RULE8

   // Per-generator list address and fetch request
   for (genvar g = 0; g < GEN_N; g++) begin : g_addr
      logic [7:0] idx;
      // Odd cycles use the alternate index
      assign idx = s_q.alt_sel[g] ? s_q.alt_idx[g] : s_q.pri_idx[g]; // RULE10
      // Index and entry count halfwords, hence the shift by one
      assign fet_addr[g] = base_ptr + MEM_AW'({idx, 1'b0})
                           + MEM_AW'({s_q.entry[g], 1'b0}); // RULE9
      assign fet_req[g] = (s_q.st[g] == GEN_FETCH);
   end

   rts_fetch u_fetch (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .req_i(fet_req),
      .addr_i(fet_addr),
      .done_o(fet_done),
      .data_o(fet_data),
      .busy_o(fet_busy),
      .owner_o(fet_owner),
      .mem_req_o(mem_req_o), // RULE7
      .mem_addr_o(mem_addr_o),
      .mem_ack_i(mem_ack_i),
      .mem_rdata_i(mem_rdata_i)
   );

   always_comb begin
      logic acc;
      logic wr;
      logic reload;
      logic [31:0] rd;
      logic hit;
      acc = psel && penable && s_q.pready;
      wr = acc && pwrite;
      reload = pwm_reload_i;
      rd = 32'h0000_0000;
      hit = 1'b1;
      s_d = s_q;
      s_d.trig = '0;
      s_d.cstart = '0;

      // Free-running time base, saturating so it cannot match twice
      if (reload) begin
         s_d.count = RST_ENTRY; // RULE3
      end else if (s_q.count != COUNT_MAX) begin
         s_d.count = s_q.count + 16'h0001; // RULE6
      end

      s_d.reload = reload && s_q.unit_en; // RULE17

      for (int g = 0; g < GEN_N; g++) begin
         if (!s_q.unit_en || !s_q.gen_en[g]) begin
            s_d.st[g] = GEN_IDLE; // RULE1
            s_d.stale[g] = s_q.stale[g] || (fet_busy && fet_owner == g[0]);
            if (fet_done[g]) begin
               s_d.stale[g] = 1'b0;
            end
         end else if (reload) begin
            // A fetch in flight for the old cycle is thrown away
            s_d.stale[g] = fet_busy && (fet_owner == g[0]);
            s_d.st[g] = GEN_FETCH; // RULE3
            s_d.entry[g] = 8'h00;
            s_d.cstart[g] = 1'b1; // RULE4
            s_d.alt_sel[g] = ~s_q.alt_sel[g]; // RULE10
         end else if (fet_done[g] && s_q.stale[g]) begin
            s_d.stale[g] = 1'b0;
         end else begin
            unique case (s_q.st[g])
               GEN_FETCH: begin
                  if (fet_done[g]) begin
                     if (s_q.entry[g] != 8'h00 && fet_data == END_MARK) begin
                        s_d.st[g] = GEN_DONE; // RULE18
                        s_d.done[g] = 1'b1; // RULE11
                     end else begin
                        s_d.value[g] = fet_data;
                        s_d.st[g] = GEN_ARMED;
                     end
                  end
               end
               GEN_ARMED: begin
                  if (s_q.count == s_q.value[g]) begin
                     s_d.trig[g] = 1'b1; // RULE5
                     s_d.entry[g] = s_q.entry[g] + 8'h01;
                     s_d.st[g] = GEN_FETCH;
                  end
               end
               GEN_IDLE: begin
                  // Waits for the next reload
               end
               GEN_DONE: begin
                  // Silent until the next reload
               end
            endcase
         end
      end

      // Transfer of partner buffers happens at the reload
      if (reload && s_q.unit_en) begin
         s_d.load_ok = 1'b0; // RULE12
      end

      // Register access: writes land on the completing edge
      unique case (paddr)
         OFS_CTRL: begin
            rd[CTRL_UNIT_EN] = s_q.unit_en;
            rd[CTRL_GEN_EN +: GEN_N] = s_q.gen_en;
            rd[CTRL_LOAD_OK] = s_q.load_ok;
            if (wr) begin
               s_d.unit_en = pwdata[CTRL_UNIT_EN];
               s_d.gen_en = pwdata[CTRL_GEN_EN +: GEN_N]; // RULE1
               // Only software sets it; set beats the reload clear
               if (pwdata[CTRL_LOAD_OK]) begin
                  s_d.load_ok = 1'b1; // RULE12
               end
            end
         end
         OFS_IRQ_EN: begin
            rd[GEN_N-1:0] = s_q.irq_en;
            if (wr) begin
               s_d.irq_en = pwdata[GEN_N-1:0];
            end
         end
         OFS_STATUS: begin
            rd[STAT_DONE +: GEN_N] = s_q.done;
            for (int g = 0; g < GEN_N; g++) begin
               rd[STAT_ACTIVE + g] = (s_q.st[g] == GEN_FETCH)
                                     || (s_q.st[g] == GEN_ARMED);
            end
            rd[STAT_ALT +: GEN_N] = s_q.alt_sel;
            // Write one to clear; a flag set now survives
            if (wr) begin
               s_d.done = (s_q.done & ~pwdata[STAT_DONE +: GEN_N])
                          | (s_d.done & ~s_q.done);
            end
         end
         OFS_BASE_LOW: begin
            rd[7:0] = s_q.base_low;
            if (wr) begin
               s_d.base_low = pwdata[7:0]; // RULE8
            end
         end
         OFS_BASE_MID: begin
            rd[7:0] = s_q.base_mid;
            if (wr) begin
               s_d.base_mid = pwdata[7:0]; // RULE8
            end
         end
         OFS_BASE_HIGH: begin
            rd[7:0] = s_q.base_high;
            if (wr) begin
               s_d.base_high = pwdata[7:0]; // RULE8
            end
         end
         OFS_GEN0_PRI: begin
            rd[7:0] = s_q.pri_idx[0];
            if (wr) begin
               s_d.pri_idx[0] = pwdata[7:0]; // RULE9
            end
         end
         OFS_GEN0_ALT: begin
            rd[7:0] = s_q.alt_idx[0];
            if (wr) begin
               s_d.alt_idx[0] = pwdata[7:0]; // RULE9
            end
         end
         OFS_GEN1_PRI: begin
            rd[7:0] = s_q.pri_idx[1];
            if (wr) begin
               s_d.pri_idx[1] = pwdata[7:0]; // RULE9
            end
         end
         OFS_GEN1_ALT: begin
            rd[7:0] = s_q.alt_idx[1];
            if (wr) begin
               s_d.alt_idx[1] = pwdata[7:0]; // RULE9
            end
         end
         OFS_COUNT: begin
            rd[ENTRY_W-1:0] = s_q.count;
         end
         default: begin
            hit = 1'b0;
         end
      endcase

      s_d.irq = s_q.done & s_q.irq_en; // RULE11

      // One wait state: ready rises in the second access cycle
      s_d.pready = psel && penable && !s_q.pready;
      s_d.pslverr = psel && penable && !s_q.pready && !hit;
      if (psel && penable && !s_q.pready) begin
         s_d.prdata = (pwrite || !hit) ? 32'h0000_0000 : rd;
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         s_q <= '0;
         s_q.st <= {GEN_N{GEN_IDLE}};
      end else begin
         s_q <= s_d;
      end
   end

   assign prdata = s_q.prdata;
   assign pready = s_q.pready;
   assign pslverr = s_q.pslverr;
   assign reload_o = s_q.reload;
   assign cycle_start_o = s_q.cstart;
   assign trigger_o = s_q.trig; // RULE2
   assign done_irq_o = s_q.irq;
   assign load_ok_o = s_q.load_ok;
endmodule : rts_sched

// >>> tb/rts_sched_checker.sv
// Port checks for the trigger scheduler
`timescale 1ns/1ps
module rts_sched_checker (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic psel,
   input wire logic penable,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic pwm_reload_i,
   input wire logic reload_o,
   input wire logic [rts_pkg::GEN_N-1:0] cycle_start_o,
   input wire logic [rts_pkg::GEN_N-1:0] trigger_o,
   input wire logic mem_req_o,
   input wire logic [rts_pkg::MEM_AW-1:0] mem_addr_o,
   input wire logic mem_ack_i
);
   import rts_pkg::*;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (sys_rst_i);
   sequence s_req;
      psel && !penable ##1 psel && penable && !pready;
   endsequence
   AST_APB_ANSWER: assert property
      (s_req |=> pready) else $error("no ready");
   AST_ERR_READY: assert property
      (pslverr |-> pready && prdata == 32'h0) else $error("bad error");
   AST_RELOAD_PASS: assert property
      (reload_o |-> $past(pwm_reload_i)) else $error("stray reload");
   AST_START_ON_RELOAD: assert property
      ((|cycle_start_o) |-> reload_o) else $error("stray start");
   AST_START_FIRST: assert property
      ((cycle_start_o & trigger_o) == 2'h0) else $error("early trigger");
   AST_TRIG_PULSE: assert property
      ((|trigger_o) |=> (trigger_o & $past(trigger_o)) == 2'h0)
      else $error("long trigger");
   AST_MEM_HOLD: assert property
      (mem_req_o && !mem_ack_i && !pwm_reload_i |=>
      mem_req_o && $stable(mem_addr_o)) else $error("request dropped");
   AST_MEM_GAP: assert property
      (mem_req_o && mem_ack_i |=> !mem_req_o) else $error("no gap");
endmodule : rts_sched_checker

bind rts_sched rts_sched_checker i_rts_sched_checker (.clk_i, .sys_rst_i,
   .psel, .penable, .prdata, .pready, .pslverr, .pwm_reload_i, .reload_o,
   .cycle_start_o, .trigger_o, .mem_req_o, .mem_addr_o, .mem_ack_i);

// >>> tb/rts_mem_model.sv
// List memory behind the scheduler's fetch port
`timescale 1ns/1ps
module rts_mem_model (
   input wire logic clk_i,
   input wire logic slow_i,
   input wire logic mem_req_i,
   input wire logic [23:0] mem_addr_i,
   output logic mem_ack_o,
   output logic [15:0] mem_rdata_o
);
   logic [15:0] mem [256];
   logic [1:0] wait_q;
   initial begin
      mem_ack_o = 1'b0;
      mem_rdata_o = 16'h0000;
      wait_q = 2'h0;
      for (int i = 0; i < 256; i++) mem[i] = 16'h0000;
      mem[8'h84] = 16'h0014;
      mem[8'h85] = 16'h001e;
      mem[8'h88] = 16'h0028;
      mem[8'h90] = 16'h0019;
   end
   // Data toggles outside an answer so stale values never match
   always @(posedge clk_i) begin
      mem_ack_o <= 1'b0;
      mem_rdata_o <= ~mem_rdata_o;
      if (mem_req_i && !mem_ack_o) begin
         wait_q <= wait_q + 2'h1;
         if (!slow_i || wait_q == 2'h3) begin
            wait_q <= 2'h0;
            mem_ack_o <= 1'b1;
            mem_rdata_o <= mem[mem_addr_i[8:1]];
         end
      end
   end
endmodule : rts_mem_model

// Converter sequencer fed by one generator's restart and trigger
module rts_conv_model #(
   parameter int FLOW_CFG = 3,
   parameter int STORE_ON_RESTART = 1,
   parameter int RESULT_RES = 4,
   parameter int JUSTIFY_MODE = 0,
   parameter int LIST_LEN = 2,
   parameter int EOL_IRQ_ENABLE = 1
) (
   input wire logic clk_i,
   input wire logic restart_i,
   input wire logic trig_i,
   output logic [7:0] seq_o,
   output logic [15:0] result_o,
   output logic eol_irq_o
);
   // Fixed sample so the result word can be checked exactly
   logic [11:0] sample = 12'habc;
   logic pending = 1'b0;
   initial begin
      seq_o = 8'h00;
      result_o = 16'h0000;
      eol_irq_o = 1'b0;
   end
   always @(posedge clk_i) begin
      if (FLOW_CFG == 3 && trig_i) begin
         pending <= 1'b1;
         seq_o <= seq_o + 8'h01;
         if (seq_o + 8'h01 == 8'(LIST_LEN) && EOL_IRQ_ENABLE == 1) begin
            eol_irq_o <= 1'b1;
         end
      end
      // A restart holds off a pending result until it drops, unless storing is on
      if (pending && (!restart_i || STORE_ON_RESTART == 1)) begin
         pending <= 1'b0;
         if (RESULT_RES == 4 && JUSTIFY_MODE == 0) begin
            result_o <= {sample, 4'h0};
         end else begin
            result_o <= {4'h0, sample};
         end
      end
      if (FLOW_CFG == 3 && restart_i) begin
         seq_o <= 8'h00;
         eol_irq_o <= 1'b0;
      end
   end
endmodule : rts_conv_model

// >>> tb/rts_sched_bench.sv
// Self-checking bench for the trigger scheduler
`timescale 1ns/1ps
module rts_sched_bench;
   import rts_pkg::*;
   logic clk_i = 1'b0, sys_rst_i = 1'b1, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, pwm_reload_i = 1'b0, slow = 1'b0, er;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic pready, pslverr, reload_o, load_ok_o, mem_req_o, mem_ack_i;
   logic [GEN_N-1:0] cycle_start_o, trigger_o, done_irq_o;
   logic [MEM_AW-1:0] mem_addr_o;
   logic [ENTRY_W-1:0] mem_rdata_i;
   logic [7:0] conv_seq [2];
   logic [15:0] conv_res [2];
   logic [1:0] conv_eol;
   int err_count = 0, checks = 0, cyc = 0;
   int tq0 [$];
   int tq1 [$];
   // Mid byte 1 puts the lists at 0x100; last row is unmapped
   logic [ADDR_W-1:0] ra [9] = '{OFS_BASE_LOW, OFS_BASE_MID, OFS_BASE_HIGH,
      OFS_GEN0_PRI, OFS_GEN0_ALT, OFS_GEN1_PRI, OFS_GEN1_ALT, OFS_IRQ_EN,
      12'h030};
   logic [31:0] rw [9] = '{32'h0, 32'h1, 32'hff00, 32'h4, 32'h8, 32'h10,
      32'h10, 32'h3, 32'hffffffff};
   logic [31:0] rr [9] = '{32'h0, 32'h1, 32'h0, 32'h4, 32'h8, 32'h10,
      32'h10, 32'h3, 32'h0};
   rts_sched i_rts_sched (.clk_i, .sys_rst_i, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .pwm_reload_i, .reload_o,
      .cycle_start_o, .trigger_o, .done_irq_o, .load_ok_o, .mem_req_o,
      .mem_addr_o, .mem_ack_i, .mem_rdata_i);
   rts_mem_model i_rts_mem_model (.clk_i, .slow_i(slow),
      .mem_req_i(mem_req_o), .mem_addr_i(mem_addr_o),
      .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i));
   rts_conv_model i_rts_conv_model_0 (.clk_i, .restart_i(cycle_start_o[0]),
      .trig_i(trigger_o[0]), .seq_o(conv_seq[0]), .result_o(conv_res[0]),
      .eol_irq_o(conv_eol[0]));
   rts_conv_model i_rts_conv_model_1 (.clk_i, .restart_i(cycle_start_o[1]),
      .trig_i(trigger_o[1]), .seq_o(conv_seq[1]), .result_o(conv_res[1]),
      .eol_irq_o(conv_eol[1]));
   initial begin
      forever #10 clk_i = ~clk_i;
   end
   // Edge count is 1 at the first edge after a reload is seen
   always @(posedge clk_i) begin
      cyc <= pwm_reload_i ? 1 : cyc + 1;
      if (trigger_o[0] === 1'b1) tq0.push_back(cyc);
      if (trigger_o[1] === 1'b1) tq1.push_back(cyc);
   end
   task automatic print_verdict();
      if (err_count == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : print_verdict
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
         input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_i);
      penable <= 1'b1;
      do begin
         @(posedge clk_i);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         err_count++;
         print_verdict();
      end
   endtask : apb
   task automatic scen(input logic [31:0] ctrl, input logic rl,
         input logic [1:0] cs, input int n0, f0, n1, f1);
      apb(1'b1, OFS_CTRL, ctrl);
      tq0.delete();
      tq1.delete();
      @(posedge clk_i);
      chk(32'(load_ok_o), 32'(ctrl[3]));
      pwm_reload_i <= 1'b1;
      @(posedge clk_i);
      pwm_reload_i <= 1'b0;
      @(posedge clk_i);
      chk(32'(reload_o), 32'(rl));
      chk(32'(cycle_start_o), 32'(cs));
      chk(32'(load_ok_o), 32'h0);
      repeat (100) @(posedge clk_i);
      chk(tq0.size(), n0);
      chk(tq1.size(), n1);
      if (n0 > 0) chk(tq0[0], f0);
      if (n1 > 0) chk(tq1[0], f1);
   endtask : scen
   initial begin
      repeat (20) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      @(posedge clk_i);
      chk(32'({reload_o, cycle_start_o, trigger_o, done_irq_o, load_ok_o,
         mem_req_o, pready}), 32'h0);
      foreach (ra[i]) begin
         apb(1'b0, ra[i], 32'h0);
         chk(rd, 32'h0);
         apb(1'b1, ra[i], rw[i]);
         chk(32'(er), 32'(i == 8));
         apb(1'b0, ra[i], 32'h0);
         chk(rd, rr[i]);
      end
      // First reload selects the alternate list
      scen(32'h3, 1'b1, 2'b01, 1, 42, 0, 0);
      chk(32'(done_irq_o), 32'h1);
      apb(1'b1, OFS_STATUS, 32'h3);
      repeat (2) @(posedge clk_i);
      chk(32'(done_irq_o), 32'h0);
      apb(1'b1, OFS_IRQ_EN, 32'h2);
      slow <= 1'b1;
      scen(32'hf, 1'b1, 2'b11, 2, 22, 1, 27);
      chk(tq0[1], 32);
      chk(32'(done_irq_o), 32'h2);
      chk(32'(conv_seq[0]), 32'h2);
      chk(32'(conv_seq[1]), 32'h1);
      chk(32'(conv_res[0]), 32'habc0);
      chk(32'(conv_eol), 32'h1);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(rd, 32'h0000_0203);
      scen(32'h5, 1'b1, 2'b10, 0, 0, 1, 27);
      scen(32'h6, 1'b0, 2'b00, 0, 0, 0, 0);
      print_verdict();
   end
endmodule : rts_sched_bench
